// File: rtl/csprs_cmd_regs.sv
// command strobes, transmit word buffer, port control and receiver sleep registers
// ----------------------------------------
// Function
// - any watchdog restart write starts a fresh 1.5 to 1.6 s period
// - watchdog expiry drives the timeout output low for 100 ms
// - after expiry rf transmit stays off until reset or restart write
// - abort write stops transmission at once, buffer kept
// - stop write ends transmission once fifth repeat begins, buffer kept
// - sync restart write forces data recovery into fast bit lock
// - soft reset write resets all like the pin, timeout output untouched
// - arbitration failure blocks transmit until re-arm write, buffer kept
// - bytes 0..3 hold word bits 35..28, 27..20, 19..12, 11..4
// - byte 4 upper nibble holds word bits 3..0, lower nibble ignored
// - direction bit 1 means output, 0 input; all default input
// - output registers set the level of pins configured as outputs
// - port three pull-up bits turn on weak pull-ups on pins configured as inputs only
// - irq control bits 3..0 make port three pins raise interrupts
// - irq control bits 7..4 pick active low or high polarity
// - sleep duration resets to 2B, timer ticks at bit rate over eight
// - each unit less shortens receiver power-down by eight bits
// - qualified first repeat drops receive enable from second repeat
// - alternate-word mode turns receiver off during the unselected word
// - alternate-word mode is off whenever sleep value is 29h or less
// - sleep mode enable bit gates first-repeat power saving, not alternate-word saving
// - port three interrupt enable gates the sensed-pin event
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none
module csprs_cmd_regs #(
	parameter int WD_CYC = csprs_pkg::WD_CYC,
	parameter int WDO_CYC = csprs_pkg::WDO_CYC
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic tx_rf_req_in,
	input wire logic tx_repeat5_in,
	input wire logic arb_fail_in,
	input wire logic [3:0] port3_pin_in,
	input wire logic port3_irq_enable_in,
	input wire logic port3_irq_ack_in,
	input wire logic rx_sleep_mode_enable_in,
	input wire logic forward_control_channel_mode_in,
	input wire logic bit_tick_in,
	input wire logic rpt1_zero_err_in,
	input wire logic rpt1_one_err_same_in,
	input wire logic rpt2_start_in,
	input wire logic unsel_word_start_in,
	output logic watchdog_timeout_n_out,
	output logic rf_transmit_enable_out,
	output logic rf_receive_enable_out,
	output logic transmit_abort_out,
	output logic transmit_stop_after_repeat_out,
	output logic bit_sync_restart_out,
	output logic arbiter_rearm_out,
	output logic chip_soft_reset_out,
	output logic tx_word_load_out,
	output logic [35:0] tx_word_out,
	output logic [7:0] port1_pin_out,
	output logic [7:0] port1_oe_out,
	output logic [7:0] port2_pin_out,
	output logic [7:0] port2_oe_out,
	output logic [3:0] port3_pin_out,
	output logic [3:0] port3_oe_out,
	output logic [3:0] port3_pullup_out,
	output logic port3_irq_pending_out
);
	localparam int WD_W = csprs_pkg::WD_W;
	localparam int WDO_W = csprs_pkg::WDO_W;

	logic srst_r, chip_rst, abort_r, stop_pend_r, stop_r, bsync_r, rearm_r, load_r;
	logic [35:0] tx_word_r;
	logic [7:0] p1dir_r, p1out_r, p2dir_r, p2out_r;
	logic [3:0] p3dir_r, p3out_r, p3pu_r;
	logic [7:0] p3irq_r;
	logic [5:0] rxslp_r;
	logic [WD_W-1:0] wd_cnt_r;
	logic wd_exp_r, wd_fire;
	logic [WDO_W-1:0] wdo_cnt_r;
	logic wdo_n_r, arb_blk_r, txen_r;
	logic [3:0] p3_sense;
	logic irq_set, irq_pend_r;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a);
		return wr_en_in && (wr_addr_in == a);
	endfunction

	// soft reset lands one cycle after the write and acts for one cycle
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			srst_r <= 1'b0;
		end else begin
			srst_r <= hit(csprs_pkg::AD_SRST);
		end
	end
	assign chip_rst = rst_in || srst_r;

	// ----------------------------------------
	// command strobes
	// ----------------------------------------
	// data byte of a strobe write is ignored
	always_ff @(posedge clk_in) begin
		if (chip_rst) begin
			abort_r <= 1'b0;
			bsync_r <= 1'b0;
			rearm_r <= 1'b0;
		end else begin
			abort_r <= hit(csprs_pkg::AD_TXABT);
			bsync_r <= hit(csprs_pkg::AD_BSYNC);
			rearm_r <= hit(csprs_pkg::AD_REARM);
		end
	end

	// stop waits for the fifth repeat; an abort makes it moot
	always_ff @(posedge clk_in) begin
		if (chip_rst) begin
			stop_pend_r <= 1'b0;
			stop_r <= 1'b0;
		end else begin
			stop_r <= stop_pend_r && tx_repeat5_in;
			if (hit(csprs_pkg::AD_TXSTP)) begin
				stop_pend_r <= 1'b1;
			end else if ((stop_pend_r && tx_repeat5_in) || abort_r) begin
				stop_pend_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// transmit word buffer
	// ----------------------------------------
	// none of the strobes except soft reset touch the buffer
	always_ff @(posedge clk_in) begin
		if (chip_rst) begin
			tx_word_r <= csprs_pkg::RST_TXW;
			load_r <= 1'b0;
		end else begin
			load_r <= hit(csprs_pkg::AD_TXB4);
			if (hit(csprs_pkg::AD_TXB0)) begin
				tx_word_r[35:28] <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_TXB1)) begin
				tx_word_r[27:20] <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_TXB2)) begin
				tx_word_r[19:12] <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_TXB3)) begin
				tx_word_r[11:4] <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_TXB4)) begin
				tx_word_r[3:0] <= wr_data_in[csprs_pkg::TXB4_LSB +: 4];
			end
		end
	end

	// ----------------------------------------
	// port and sleep registers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (chip_rst) begin
			p1dir_r <= csprs_pkg::RST_P12;
			p1out_r <= csprs_pkg::RST_P12;
			p2dir_r <= csprs_pkg::RST_P12;
			p2out_r <= csprs_pkg::RST_P12;
			p3dir_r <= csprs_pkg::RST_P3;
			p3out_r <= csprs_pkg::RST_P3;
			p3pu_r <= csprs_pkg::RST_P3;
			p3irq_r <= csprs_pkg::RST_P3IRQ;
			rxslp_r <= csprs_pkg::RST_RXSLP;
		end else begin
			if (hit(csprs_pkg::AD_P1DIR)) begin
				p1dir_r <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_P1OUT)) begin
				p1out_r <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_P2DIR)) begin
				p2dir_r <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_P2OUT)) begin
				p2out_r <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_P3DIR)) begin
				p3dir_r <= wr_data_in[3:0];
			end
			if (hit(csprs_pkg::AD_P3OUT)) begin
				p3out_r <= wr_data_in[3:0];
			end
			if (hit(csprs_pkg::AD_P3PU)) begin
				p3pu_r <= wr_data_in[3:0];
			end
			if (hit(csprs_pkg::AD_P3IRQ)) begin
				p3irq_r <= wr_data_in;
			end
			if (hit(csprs_pkg::AD_RXSLP)) begin
				rxslp_r <= wr_data_in[5:0];
			end
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	// period is the lower bound itself, so expiry lands at the start of the window
	always_ff @(posedge clk_in) begin
		if (chip_rst) begin
			wd_cnt_r <= '0;
			wd_exp_r <= 1'b0;
		end else if (hit(csprs_pkg::AD_WDOG)) begin
			wd_cnt_r <= WD_W'(WD_CYC);
			wd_exp_r <= 1'b0;
		end else if (wd_fire) begin
			wd_cnt_r <= '0;
			wd_exp_r <= 1'b1;
		end else if (wd_cnt_r != '0) begin
			wd_cnt_r <= wd_cnt_r - WD_W'(1);
		end
	end
	assign wd_fire = (wd_cnt_r == WD_W'(1)) && !hit(csprs_pkg::AD_WDOG) && !chip_rst;

	// pulse sits on the pin reset only, so a soft reset cannot cut it short
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wdo_cnt_r <= '0;
			wdo_n_r <= 1'b1;
		end else begin
			wdo_n_r <= !(wd_fire || (wdo_cnt_r > WDO_W'(1)));
			if (wd_fire) begin
				wdo_cnt_r <= WDO_W'(WDO_CYC);
			end else if (wdo_cnt_r != '0) begin
				wdo_cnt_r <= wdo_cnt_r - WDO_W'(1);
			end
		end
	end

	// ----------------------------------------
	// arbitration block and rf transmit gate
	// ----------------------------------------
	// a failure in the same cycle as the re-arm write wins
	always_ff @(posedge clk_in) begin
		if (chip_rst) begin
			arb_blk_r <= 1'b0;
			txen_r <= 1'b0;
		end else begin
			if (arb_fail_in) begin
				arb_blk_r <= 1'b1;
			end else if (hit(csprs_pkg::AD_REARM)) begin
				arb_blk_r <= 1'b0;
			end
			txen_r <= tx_rf_req_in && !wd_exp_r && !arb_blk_r;
		end
	end

	// ----------------------------------------
	// port three interrupt
	// ----------------------------------------
	// sense is a level and wins over ack, so a held pin keeps the flag set through service
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			p3_sense[i] = p3irq_r[i] &&
				(port3_pin_in[i] == p3irq_r[csprs_pkg::P3IRQ_POL_LSB + i]);
		end
	end
	assign irq_set = port3_irq_enable_in && (p3_sense != 4'h0);

	always_ff @(posedge clk_in) begin
		if (chip_rst) begin
			irq_pend_r <= 1'b0;
		end else if (irq_set) begin
			irq_pend_r <= 1'b1;
		end else if (port3_irq_ack_in) begin
			irq_pend_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// receiver sleep timer
	// ----------------------------------------
	csprs_slp_if slp ();
	assign slp.duration = rxslp_r;
	assign slp.bit_tick = bit_tick_in;
	assign slp.forward_control_channel_mode = forward_control_channel_mode_in;
	assign slp.sleep_en = rx_sleep_mode_enable_in;
	assign slp.rpt1_zero_err = rpt1_zero_err_in;
	assign slp.rpt1_one_err_same = rpt1_one_err_same_in;
	assign slp.rpt2_start = rpt2_start_in;
	assign slp.unsel_start = unsel_word_start_in;

	csprs_rx_sleep u_sleep (
		.clk_in(clk_in),
		.rst_in(chip_rst),
		.s(slp.tmr)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign watchdog_timeout_n_out = wdo_n_r;
	assign rf_transmit_enable_out = txen_r;
	assign rf_receive_enable_out = slp.rx_enable;
	assign transmit_abort_out = abort_r;
	assign transmit_stop_after_repeat_out = stop_r;
	assign bit_sync_restart_out = bsync_r;
	assign arbiter_rearm_out = rearm_r;
	assign chip_soft_reset_out = srst_r;
	assign tx_word_load_out = load_r;
	assign tx_word_out = tx_word_r;
	assign port1_pin_out = p1out_r;
	assign port1_oe_out = p1dir_r;
	assign port2_pin_out = p2out_r;
	assign port2_oe_out = p2dir_r;
	assign port3_pin_out = p3out_r;
	assign port3_oe_out = p3dir_r;
	assign port3_pullup_out = p3pu_r & ~p3dir_r;
	assign port3_irq_pending_out = irq_pend_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_soft_reset;
		hit(csprs_pkg::AD_SRST) ##1 chip_soft_reset_out;
	endsequence

	chk_wdog_restart: assert property (hit(csprs_pkg::AD_WDOG) && !srst_r |=>
		wd_cnt_r == WD_W'(WD_CYC) && !wd_exp_r)
		else $error("watchdog restart did not reload the period");
	chk_wdo_pulse: assert property (wd_fire |=> !watchdog_timeout_n_out &&
		wdo_cnt_r == WDO_W'(WDO_CYC))
		else $error("timeout pulse not started on expiry");
	chk_tx_gate: assert property (wd_exp_r |=> !rf_transmit_enable_out)
		else $error("rf transmit enabled after watchdog expiry");
	chk_abort_now: assert property (hit(csprs_pkg::AD_TXABT) && !srst_r |=>
		transmit_abort_out && $stable(tx_word_out))
		else $error("abort not issued at once or buffer changed");
	chk_arb_block: assert property (arb_fail_in && !chip_rst |=>
		##1 !rf_transmit_enable_out)
		else $error("transmit not blocked after arbitration failure");
	chk_byte4_nibble: assert property (hit(csprs_pkg::AD_TXB4) && !srst_r |=>
		tx_word_out[3:0] == $past(wr_data_in[7:4]) && tx_word_load_out)
		else $error("last byte upper nibble not stored");
	chk_soft_reset: assert property (s_soft_reset |=> port1_oe_out == 8'h00 &&
		rf_receive_enable_out)
		else $error("soft reset did not restore defaults");
	chk_irq_latch: assert property (irq_set && !chip_rst |=> port3_irq_pending_out ##1
		(port3_irq_pending_out || $past(port3_irq_ack_in) || $past(srst_r)))
		else $error("port three event not held pending");
endmodule
`default_nettype wire

// File: pkg/csprs_pkg.sv
// constants for the command strobe, port and receiver sleep register block
package csprs_pkg;
	// write addresses
	localparam logic [7:0] AD_WDOG = 8'h09;
	localparam logic [7:0] AD_TXABT = 8'h0A;
	localparam logic [7:0] AD_TXSTP = 8'h0B;
	localparam logic [7:0] AD_BSYNC = 8'h0C;
	localparam logic [7:0] AD_SRST = 8'h0D;
	localparam logic [7:0] AD_REARM = 8'h0E;
	localparam logic [7:0] AD_TXB0 = 8'h10;
	localparam logic [7:0] AD_TXB1 = 8'h11;
	localparam logic [7:0] AD_TXB2 = 8'h12;
	localparam logic [7:0] AD_TXB3 = 8'h13;
	localparam logic [7:0] AD_TXB4 = 8'h14;
	localparam logic [7:0] AD_P1DIR = 8'h15;
	localparam logic [7:0] AD_P1OUT = 8'h16;
	localparam logic [7:0] AD_P2DIR = 8'h17;
	localparam logic [7:0] AD_P2OUT = 8'h18;
	localparam logic [7:0] AD_P3DIR = 8'h19;
	localparam logic [7:0] AD_P3OUT = 8'h1A;
	localparam logic [7:0] AD_P3PU = 8'h1B;
	localparam logic [7:0] AD_P3IRQ = 8'h1C;
	localparam logic [7:0] AD_RXSLP = 8'h20;
	// reset values
	localparam logic [7:0] RST_P12 = 8'h00;
	localparam logic [3:0] RST_P3 = 4'h0;
	localparam logic [7:0] RST_P3IRQ = 8'h00;
	localparam logic [5:0] RST_RXSLP = 6'h2B;
	localparam logic [35:0] RST_TXW = 36'h0;
	// field layout: last byte carries word bits 3..0 in its upper nibble
	localparam int TXB4_LSB = 4;
	localparam int P3IRQ_POL_LSB = 4;
	// alternate-word saving is off at or below this sleep value
	localparam logic [5:0] ALT_OFF_MAX = 6'h29;
	// sleep timer runs at bit rate divided by eight
	localparam logic [2:0] SLP_PRE_LAST = 3'h7;
	// timing
	localparam int CLK_KHZ = 250000;
	localparam int WD_MIN_MS = 1500;
	localparam int WD_MAX_MS = 1600;
	localparam int WDO_MS = 100;
	localparam int WD_CYC = WD_MIN_MS * CLK_KHZ;
	localparam int WDO_CYC = WDO_MS * CLK_KHZ;
	localparam int WD_W = 29;
	localparam int WDO_W = 25;
endpackage

// File: pkg/csprs_slp_if.sv
// link between the register block and the receiver sleep timer
`timescale 1ns/10ps
`default_nettype none
interface csprs_slp_if;
	logic [5:0] duration;
	logic bit_tick;
	logic forward_control_channel_mode;
	logic sleep_en;
	logic rpt1_zero_err;
	logic rpt1_one_err_same;
	logic rpt2_start;
	logic unsel_start;
	logic rx_enable;
	modport ctl (output duration, bit_tick, forward_control_channel_mode, sleep_en, rpt1_zero_err,
		rpt1_one_err_same, rpt2_start, unsel_start, input rx_enable);
	modport tmr (input duration, bit_tick, forward_control_channel_mode, sleep_en, rpt1_zero_err,
		rpt1_one_err_same, rpt2_start, unsel_start, output rx_enable);
endinterface
`default_nettype wire

// File: rtl/csprs_rx_sleep.sv
// receiver power-saving timer driving the rf receive enable
`timescale 1ns/10ps
`default_nettype none
module csprs_rx_sleep (
	input wire logic clk_in,
	input wire logic rst_in,
	csprs_slp_if.tmr s
);
	typedef enum logic [1:0] {SLP_ON, SLP_NORM, SLP_ALT} csprs_slp_st_t;
	csprs_slp_st_t st_r;
	logic [5:0] cnt_r;
	logic [2:0] pre_r;
	logic qual;
	logic alt_ok;
	logic norm_go;
	logic alt_go;

	// ----------------------------------------
	// entry conditions
	// ----------------------------------------
	// first-repeat verdict is sampled as a level at the start of the second repeat
	assign qual = s.forward_control_channel_mode && s.sleep_en &&
		(s.rpt1_zero_err || s.rpt1_one_err_same);
	assign alt_ok = s.duration > csprs_pkg::ALT_OFF_MAX;
	assign norm_go = s.rpt2_start && qual && (s.duration != 6'h00);
	// alt-word saving ignores first-repeat errors
	assign alt_go = s.unsel_start && alt_ok;

	// ----------------------------------------
	// sleep state and timer
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st_r <= SLP_ON;
			cnt_r <= 6'h00;
			pre_r <= 3'h0;
		end else begin
			case (st_r)
				SLP_ON: begin
					pre_r <= 3'h0;
					if (norm_go) begin
						st_r <= SLP_NORM;
						cnt_r <= s.duration;
					end else if (alt_go) begin
						st_r <= SLP_ALT;
						cnt_r <= s.duration - csprs_pkg::ALT_OFF_MAX;
					end
				end
				SLP_NORM, SLP_ALT: begin
					// one timer unit is eight bit periods
					if (s.bit_tick) begin
						pre_r <= pre_r + 3'h1;
						if (pre_r == csprs_pkg::SLP_PRE_LAST) begin
							cnt_r <= cnt_r - 6'h01;
							if (cnt_r == 6'h01) begin
								st_r <= SLP_ON;
							end
						end
					end
				end
				default: begin
					st_r <= SLP_ON;
				end
			endcase
		end
	end

	assign s.rx_enable = (st_r == SLP_ON);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	chk_norm_sleep: assert property ((st_r == SLP_ON) && norm_go |=> !s.rx_enable)
		else $error("receiver not powered down after qualified first repeat");
	chk_alt_gate: assert property (s.duration <= csprs_pkg::ALT_OFF_MAX |=>
		st_r != SLP_ALT || $past(st_r) == SLP_ALT)
		else $error("alternate-word sleep entered at low sleep value");
	chk_sleep_unit: assert property (st_r != SLP_ON && !s.bit_tick |=> $stable(cnt_r))
		else $error("sleep timer moved without a bit tick");
endmodule
`default_nettype wire

// File: verif/csprs_host_model.sv
// host-side model: register writes toward the command block
`timescale 1ns/10ps
`default_nettype none
module csprs_host_model (
	input wire logic clk_in,
	output logic wr_en_out,
	output logic [7:0] wr_addr_out,
	output logic [7:0] wr_data_out
);
	// ----------------------------------------
	// write port
	// ----------------------------------------
	initial begin
		wr_en_out = 1'b0;
		wr_addr_out = 8'h00;
		wr_data_out = 8'h00;
	end
	// one write word; callers leave a free edge before the next call
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		wr_en_out = 1'b1;
		wr_addr_out = a;
		wr_data_out = d;
		@(posedge clk_in);
		#1;
		wr_en_out = 1'b0;
		// released data shows the inverse so a stray sample is caught
		wr_data_out = ~d;
	endtask
	// watchdog service, spaced by callers inside the period or sent after expiry to restart it
	task automatic kick();
		write(csprs_pkg::AD_WDOG, 8'hA5);
	endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the command strobe, port and sleep register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic [3:0] pin;
		logic en;
		logic [3:0] sel;
		logic [39:0] exp;
	} csprs_row_t;
	logic clk_in = 1'b0, rst_in = 1'b1, wr_en;
	logic [7:0] wr_addr, wr_data;
	logic tx_rf_req = 1'b1, tx_rep5 = 1'b0, arb_fail = 1'b0, p3_en = 1'b0, p3_ack = 1'b0;
	logic [3:0] p3_pin = 4'h0;
	logic slp_en = 1'b0, forward_control_channel = 1'b0, btick = 1'b0, zero = 1'b0, one = 1'b0;
	logic rpt2 = 1'b0, unsel = 1'b0;
	logic wd_n, rf_tx, rf_rx, abt, stp, bsy, rearm, srst, ld, pend;
	logic [35:0] word;
	logic [7:0] p1, p1oe, p2, p2oe;
	logic [3:0] p3, p3oe, pu;
	int fail_count = 0;
	int tests_run = 0;
	always #2 clk_in = ~clk_in;
	csprs_cmd_regs #(.WD_CYC(200), .WDO_CYC(50)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
		.wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
		.tx_rf_req_in(tx_rf_req), .tx_repeat5_in(tx_rep5), .arb_fail_in(arb_fail),
		.port3_pin_in(p3_pin), .port3_irq_enable_in(p3_en), .port3_irq_ack_in(p3_ack),
		.rx_sleep_mode_enable_in(slp_en), .forward_control_channel_mode_in(forward_control_channel), .bit_tick_in(btick),
		.rpt1_zero_err_in(zero), .rpt1_one_err_same_in(one), .rpt2_start_in(rpt2),
		.unsel_word_start_in(unsel), .watchdog_timeout_n_out(wd_n),
		.rf_transmit_enable_out(rf_tx), .rf_receive_enable_out(rf_rx),
		.transmit_abort_out(abt), .transmit_stop_after_repeat_out(stp),
		.bit_sync_restart_out(bsy), .arbiter_rearm_out(rearm), .chip_soft_reset_out(srst),
		.tx_word_load_out(ld), .tx_word_out(word), .port1_pin_out(p1), .port1_oe_out(p1oe),
		.port2_pin_out(p2), .port2_oe_out(p2oe), .port3_pin_out(p3), .port3_oe_out(p3oe),
		.port3_pullup_out(pu), .port3_irq_pending_out(pend));
	csprs_host_model u_host (.clk_in(clk_in), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
		.wr_data_out(wr_data));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	function automatic logic [39:0] obs(input logic [3:0] sel);
		case (sel)
			4'h0: obs = 40'(p1);
			4'h1: obs = 40'(p1oe);
			4'h2: obs = 40'(p2);
			4'h3: obs = 40'(p2oe);
			4'h4: obs = 40'(p3);
			4'h5: obs = 40'(p3oe);
			4'h6: obs = 40'(pu);
			4'h7: obs = {3'h0, ld, word};
			default: obs = 40'(pend);
		endcase
	endfunction
	// n is the expected count of bit ticks the receiver stays off; 0 means no sleep
	task automatic slp(input logic [7:0] dur, input logic f, input logic en, input logic z,
		input logic o, input logic un, input int n);
		int i;
		if (dur != 8'hFF) u_host.write(csprs_pkg::AD_RXSLP, dur);
		forward_control_channel = f;
		slp_en = en;
		zero = z;
		one = o;
		cyc(1);
		unsel = un;
		rpt2 = ~un;
		cyc(1);
		unsel = 1'b0;
		rpt2 = 1'b0;
		check("rx_entry", rf_rx, n == 0);
		for (i = 1; i <= n; i++) begin
			btick = 1'b1;
			cyc(1);
			btick = 1'b0;
			cyc(1);
			check("rx_sleep", rf_rx, i == n);
		end
	endtask
	// ----------------------------------------
	// table of register writes
	// ----------------------------------------
	localparam csprs_row_t ROWS [17] = '{
		'{8'h15, 8'hFF, 4'h0, 1'b0, 4'h1, 40'hFF},
		'{8'h16, 8'h5A, 4'h0, 1'b0, 4'h0, 40'h5A},
		'{8'h17, 8'h0F, 4'h0, 1'b0, 4'h3, 40'h0F},
		'{8'h18, 8'hC3, 4'h0, 1'b0, 4'h2, 40'hC3},
		'{8'h19, 8'h05, 4'h0, 1'b0, 4'h5, 40'h5},
		'{8'h1A, 8'h0A, 4'h0, 1'b0, 4'h4, 40'hA},
		'{8'h1B, 8'h0F, 4'h0, 1'b0, 4'h6, 40'hA}, // outputs keep pull-up off
		'{8'h10, 8'hA5, 4'h0, 1'b0, 4'hF, 40'h0},
		'{8'h11, 8'h3C, 4'h0, 1'b0, 4'hF, 40'h0},
		'{8'h12, 8'hF0, 4'h0, 1'b0, 4'hF, 40'h0},
		'{8'h13, 8'h81, 4'h0, 1'b0, 4'hF, 40'h0},
		'{8'h14, 8'h9F, 4'h0, 1'b0, 4'h7, 40'h1A53CF0819}, // last byte
		'{8'h1C, 8'h11, 4'h1, 1'b1, 4'h8, 40'h1},
		'{8'h1C, 8'h11, 4'h0, 1'b1, 4'h8, 40'h0},
		'{8'h1C, 8'h11, 4'h1, 1'b0, 4'h8, 40'h0},
		'{8'h1C, 8'h01, 4'h0, 1'b1, 4'h8, 40'h1},
		'{8'h1C, 8'h00, 4'h0, 1'b1, 4'h8, 40'h0}
	};
	localparam logic [7:0] STB_A [3] = '{csprs_pkg::AD_TXABT, csprs_pkg::AD_BSYNC,
		csprs_pkg::AD_REARM};
	localparam logic [4:0] STB_V [3] = '{5'h10, 5'h04, 5'h02};
	initial begin
		repeat (5000) @(posedge clk_in);
		fail_count++;
		end_sim();
	end
	initial begin
		csprs_row_t r;
		int i;
		repeat (6) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		check("rst_ports", {p1oe, p2oe, p3oe, p1, p2, p3}, 40'h0);
		check("rst_misc", {wd_n, rf_rx, pend, word}, {3'b110, 36'h0});
		slp(8'hFF, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16); // default value
		for (i = 0; i < 17; i++) begin
			r = ROWS[i];
			p3_pin = r.pin;
			p3_en = r.en;
			u_host.write(r.addr, r.data);
			if (r.sel < 4'h8) check("reg", obs(r.sel), r.exp);
			p3_ack = 1'b1;
			cyc(1);
			p3_ack = 1'b0;
			cyc(1);
			if (r.sel == 4'h8) check("irq", obs(r.sel), r.exp);
		end
		for (i = 0; i < 3; i++) begin
			u_host.write(STB_A[i], 8'h00);
			check("strobe", {abt, stp, bsy, rearm, srst}, STB_V[i]);
			cyc(1);
			check("strobe_end", {abt, stp, bsy, rearm, srst}, 5'h00);
			check("tx_kept", word, 36'hA53CF0819);
		end
		u_host.write(csprs_pkg::AD_TXSTP, 8'h00);
		check("stop_wait", stp, 1'b0);
		tx_rep5 = 1'b1;
		cyc(1);
		check("stop_fire", stp, 1'b1);
		cyc(1);
		check("stop_once", {stp, word}, {1'b0, 36'hA53CF0819});
		tx_rep5 = 1'b0;
		check("tx_on", rf_tx, 1'b1);
		arb_fail = 1'b1;
		cyc(1);
		arb_fail = 1'b0;
		cyc(5);
		check("arb_block", rf_tx, 1'b0);
		u_host.write(csprs_pkg::AD_REARM, 8'h00);
		cyc(1);
		check("arb_rearm", {rf_tx, word}, {1'b1, 36'hA53CF0819});
		slp(8'h02, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 16);
		slp(8'h02, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 16);
		slp(8'h02, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 0);
		slp(8'h02, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 0);
		slp(8'h02, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 0);
		slp(8'h2A, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8);
		slp(8'h29, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 0);
		u_host.kick();
		cyc(150);
		u_host.kick();
		cyc(199);
		check("wd_hold", wd_n, 1'b1); // restarted period still running
		cyc(1);
		check("wd_fire", wd_n, 1'b0);
		cyc(2);
		check("wd_txoff", rf_tx, 1'b0);
		u_host.kick();
		cyc(2);
		check("wd_txback", rf_tx, 1'b1);
		cyc(197);
		check("wd_hold2", wd_n, 1'b1);
		cyc(1);
		check("wd_fire2", wd_n, 1'b0);
		u_host.write(csprs_pkg::AD_SRST, 8'h00);
		check("srst", srst, 1'b1);
		cyc(48);
		check("wd_low", {wd_n, p1oe, p2}, 40'h0); // pulse kept, defaults loaded
		check("srst_word", word, 40'h0);
		cyc(1);
		check("wd_end", wd_n, 1'b1);
		end_sim();
	end
endmodule
`default_nettype wire
